// >>> pkg/plrc_pkg.sv
// Purpose: Shared constants and types for the power loss restore control block.
// Assumes: A 10 MHz standby-domain clock.
// Notes:   The monitoring window is held in seconds and converted to cycles here.
`default_nettype none
package plrc_pkg;
    localparam longint unsigned CLK_HZ        = 64'h989680;
    localparam longint unsigned MON_SECONDS   = 64'h1E;
    localparam longint unsigned MON_CYCLES    = MON_SECONDS * CLK_HZ;
    localparam int              CNT_W         = 29;
    localparam logic [1:0]      POL_TURN_ON   = 2'h0;
    localparam logic [1:0]      POL_REMAIN    = 2'h1;
    localparam logic [1:0]      POL_LAST      = 2'h2;
    localparam logic            STATE_RESET   = 1'h0;

    typedef enum logic [2:0] {
        PLRC_OFF_IDLE,
        PLRC_MONITOR,
        PLRC_ON,
        PLRC_DECIDE
    } plrc_state_e;
endpackage : plrc_pkg
`default_nettype wire

// >>> design/plrc_state_store.sv
// Purpose: One-bit store for the last system state that survives standby loss.
// Assumes: Its clear input is separate from the standby-domain reset.
// Notes:   Models a battery-backed cell; of the two resets only porRst_b, not rst_b, clears it.
`default_nettype none
module plrc_state_store (
    input  wire logic clk,
    input  wire logic porRst_b,
    input  wire logic wrEn,
    input  wire logic wrData,
    output logic      rdData
);
    always_ff @(posedge clk or negedge porRst_b) begin
        if (!porRst_b) begin
            rdData <= plrc_pkg::STATE_RESET;
        end else if (wrEn) begin
            rdData <= wrData;
        end
    end
endmodule : plrc_state_store
`default_nettype wire

// >>> design/plrc_power_loss_ctrl.sv
// Purpose: Decide power-on behaviour when standby power returns.
// Assumes: Inputs synchronous to clk; rst_b follows the standby rail.
// Notes:   monCycles is a parameter so simulation can shorten 30 s.
`default_nettype none
module plrc_power_loss_ctrl #(
    parameter longint unsigned monCycles = plrc_pkg::MON_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       porRst_b,
    input  wire logic       standbyGood,
    input  wire logic       standbyRailPresent,
    input  wire logic [1:0] lossPolicy,
    input  wire logic       sysOn,
    output logic            powerOnReq,
    output logic            orderlyOff,
    output logic            acLossSeen
);
    localparam int                         CW       = plrc_pkg::CNT_W;
    localparam logic [plrc_pkg::CNT_W-1:0] CNT_END  = CW'(monCycles - 64'h1);
    localparam logic [plrc_pkg::CNT_W-1:0] CNT_STEP = CW'(32'h1);

    plrc_pkg::plrc_state_e          state;
    logic [plrc_pkg::CNT_W-1:0]     monCount;
    logic                           lastState;
    logic                           storeWr;
    logic                           storeData;
    logic                           sysOnPrev;
    logic                           decideOn;

    function automatic logic policyOn(input logic [1:0] pol, input logic last);
        case (pol)
            plrc_pkg::POL_TURN_ON: policyOn = 1'h1;
            plrc_pkg::POL_REMAIN:  policyOn = 1'h0;
            plrc_pkg::POL_LAST:    policyOn = last;
            default:               policyOn = 1'h0;
        endcase
    endfunction : policyOn

    // One decode of the window end keeps the store and the flag in step; the state block compares monCount to CNT_END itself.
    function automatic logic atWindowEnd(input plrc_pkg::plrc_state_e st,
                                         input logic [plrc_pkg::CNT_W-1:0] cnt);
        atWindowEnd = (st == plrc_pkg::PLRC_MONITOR) && (cnt == CNT_END);
    endfunction : atWindowEnd

    // Powering on marks the last state as on; the window only later clears it,
    // so a loss inside the window keeps "on", which is accepted behaviour.
    assign storeWr   = (sysOn && !sysOnPrev) ||
                       atWindowEnd(state, monCount);
    assign storeData = sysOn;
    assign decideOn  = standbyRailPresent && policyOn(lossPolicy, lastState);

    plrc_state_store u_store (
        .clk      (clk),
        .porRst_b (porRst_b),
        .wrEn     (storeWr),
        .wrData   (storeData),
        .rdData   (lastState)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sysOnPrev <= 1'h0;
        end else begin
            sysOnPrev <= sysOn;
        end
    end

    // Reset means standby just returned, so the first step is the policy choice.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= plrc_pkg::PLRC_DECIDE;
        end else begin
            case (state)
                plrc_pkg::PLRC_DECIDE:   state <= decideOn ? plrc_pkg::PLRC_ON
                                                           : plrc_pkg::PLRC_OFF_IDLE;
                plrc_pkg::PLRC_ON: begin
                    if (!sysOn) begin
                        state <= (lossPolicy == plrc_pkg::POL_LAST)
                               ? plrc_pkg::PLRC_MONITOR : plrc_pkg::PLRC_OFF_IDLE;
                    end
                end
                plrc_pkg::PLRC_MONITOR: begin
                    if (sysOn) begin
                        state <= plrc_pkg::PLRC_ON;
                    end else if (monCount == CNT_END) begin
                        state <= plrc_pkg::PLRC_OFF_IDLE;
                    end
                end
                plrc_pkg::PLRC_OFF_IDLE: begin
                    if (sysOn) begin
                        state <= plrc_pkg::PLRC_ON;
                    end
                end
                default: state <= plrc_pkg::PLRC_OFF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            monCount <= '0;
        end else if (state != plrc_pkg::PLRC_MONITOR) begin
            monCount <= '0;
        end else if (monCount != CNT_END) begin
            monCount <= monCount + CNT_STEP;
        end
    end

    // The request is a single pulse, so a held line cannot switch the system
    // on again after it has shut itself down.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            powerOnReq <= 1'h0;
        end else begin
            powerOnReq <= (state == plrc_pkg::PLRC_DECIDE) && decideOn;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            orderlyOff <= 1'h0;
        end else if (atWindowEnd(state, monCount)) begin
            orderlyOff <= 1'h1;
        end else if (sysOn) begin
            orderlyOff <= 1'h0;
        end
    end

    // Standby loss mid-window appears as a drop of standbyGood before reset hits.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acLossSeen <= 1'h0;
        end else if (state == plrc_pkg::PLRC_MONITOR && !standbyGood) begin
            acLossSeen <= 1'h1;
        end else if (sysOn) begin
            acLossSeen <= 1'h0;
        end
    end

    AST_REMAIN_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_DECIDE && lossPolicy == plrc_pkg::POL_REMAIN
        |=> !powerOnReq)
        else $error("Remain-off policy requested power on.");
    AST_TURN_ON: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_DECIDE && standbyRailPresent
        && lossPolicy == plrc_pkg::POL_TURN_ON |=> powerOnReq)
        else $error("Turn-on policy did not request power on.");
    AST_LAST_STATE: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_DECIDE && standbyRailPresent
        && lossPolicy == plrc_pkg::POL_LAST |=> powerOnReq == $past(lastState))
        else $error("Last-state policy did not follow stored state.");
    AST_NO_RAIL: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(standbyRailPresent) |-> !powerOnReq)
        else $error("Policy acted without a standby rail.");
    AST_MON_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_ON && !sysOn && lossPolicy == plrc_pkg::POL_LAST
        |=> state == plrc_pkg::PLRC_MONITOR && monCount == '0)
        else $error("Monitoring did not start at shutdown.");
    AST_NO_MON: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_ON && !sysOn && lossPolicy != plrc_pkg::POL_LAST
        |=> state == plrc_pkg::PLRC_OFF_IDLE)
        else $error("Monitoring used outside last-state policy.");
    AST_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_MONITOR && $past(state) == plrc_pkg::PLRC_MONITOR
        && monCount != '0 |-> monCount == $past(monCount) + CNT_STEP)
        else $error("Monitoring counter skipped.");
    AST_ORDERLY: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_MONITOR && monCount == CNT_END && !sysOn
        |=> orderlyOff && state == plrc_pkg::PLRC_OFF_IDLE)
        else $error("Full window did not give orderly switch-off.");
    AST_AC_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_MONITOR && !standbyGood |=> acLossSeen)
        else $error("Standby drop in window not flagged.");
    AST_STORE: assert property (@(posedge clk) disable iff (!rst_b)
        sysOn && !sysOnPrev |=> lastState)
        else $error("Power-on not recorded as last state.");

    // The hold checks below also catch a flag or a stored state that is lost
    // without a power-on, which the set checks alone would miss.
    AST_REQ_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
        powerOnReq
        |=> !powerOnReq)
        else $error("Power-on request lasted more than one cycle.");
    AST_REQ_SOURCE: assert property (@(posedge clk) disable iff (!rst_b)
        powerOnReq
        |-> $past(state) == plrc_pkg::PLRC_DECIDE && $past(standbyRailPresent))
        else $error("Power-on request outside the return decision.");
    AST_WINDOW_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        atWindowEnd(state, monCount) && !sysOn
        |=> !lastState)
        else $error("Full window did not record the off state.");
    AST_EARLY_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_MONITOR && !sysOn && !atWindowEnd(state, monCount)
        |=> $stable(lastState))
        else $error("Last state changed inside the window.");
    AST_COUNT_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        state != plrc_pkg::PLRC_MONITOR
        |=> monCount == '0)
        else $error("Monitoring counter not restarted.");
    AST_COUNT_BOUND: assert property (@(posedge clk) disable iff (!rst_b)
        state == plrc_pkg::PLRC_MONITOR
        |-> monCount <= CNT_END)
        else $error("Monitoring counter passed the window end.");
    AST_ORDERLY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        orderlyOff && !sysOn
        |=> orderlyOff)
        else $error("Orderly switch-off flag lost while off.");
    AST_LOSS_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        acLossSeen && !sysOn
        |=> acLossSeen)
        else $error("Power loss flag lost while off.");
endmodule : plrc_power_loss_ctrl
`default_nettype wire

// >>> sim/plrc_psu_model.sv
// Purpose: Supply model with a standby rail for the power loss restore control.
// Assumes: The standby-domain reset follows the rail.
// Notes:   Reset lags good by three cycles, so a rail drop is seen before reset.
`default_nettype none
module plrc_psu_model (
    input  wire logic clk,
    input  wire logic acOn,
    output logic      standbyGood,
    output logic      railRst_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] sr = 4'h0;
    always @(posedge clk) begin
        sr <= {sr[2:0], acOn};
    end
    assign standbyGood = sr[0];
    assign railRst_b   = sr[3];
endmodule : plrc_psu_model
`default_nettype wire

// >>> sim/plrc_power_loss_ctrl_tb_top.sv
// Purpose: Self-checking bench for the power loss restore control.
// Assumes: The window is shortened to MON cycles.
// Notes:   Inputs change on the falling edge of the clock.
`default_nettype none
module plrc_power_loss_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint unsigned MON = 64'h14;
    logic       clk = 1'h0;
    logic       benchRst_b;
    logic       porRst_b;
    logic       acOn;
    logic       railPresent;
    logic [1:0] policy;
    logic       sysOn;
    logic       standbyGood;
    logic       railRst_b;
    logic       powerOnReq;
    logic       orderlyOff;
    logic       acLossSeen;
    int         errors = 0;
    int         compares = 0;
    always #50 clk = ~clk;
    plrc_psu_model psu (.clk(clk), .acOn(acOn), .standbyGood(standbyGood),
        .railRst_b(railRst_b));
    plrc_power_loss_ctrl #(.monCycles(MON)) dut (.clk(clk), .rst_b(benchRst_b & railRst_b),
        .porRst_b(porRst_b), .standbyGood(standbyGood), .standbyRailPresent(railPresent),
        .lossPolicy(policy), .sysOn(sysOn), .powerOnReq(powerOnReq),
        .orderlyOff(orderlyOff), .acLossSeen(acLossSeen));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // The system cannot stay on without power, so sysOn falls with the supply.
    task automatic cycle_power(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        acOn = 1'h0;
        sysOn = 1'h0;
        cyc(6);
        acOn = 1'h1;
        repeat (12) begin
            @(negedge clk);
            if (powerOnReq === 1'h1) n = n + 8'h01;
        end
        chk(n, exp, "power-on request count");
    endtask : cycle_power
    task automatic t_policies;
        for (int p = 0; p < 4; p++) begin
            policy = 2'(p);
            cycle_power((p == 0) ? 8'h01 : 8'h00);
        end
        railPresent = 1'h0;
        policy = 2'h0;
        cycle_power(8'h00);
        railPresent = 1'h1;
        $display("policies done");
    endtask : t_policies
    task automatic t_orderly;
        policy = 2'h1;
        sysOn = 1'h1;
        cyc(3);
        sysOn = 1'h0;
        cyc(int'(MON) + 5);
        chk(orderlyOff, 1'h0, "window outside last-state");
        policy = 2'h2;
        sysOn = 1'h1;
        cyc(3);
        sysOn = 1'h0;
        cyc(10);
        sysOn = 1'h1;
        cyc(3);
        sysOn = 1'h0;
        cyc(int'(MON) - 5);
        chk(orderlyOff, 1'h0, "window not restarted");
        cyc(10);
        chk(orderlyOff, 1'h1, "orderly off missing");
        chk(acLossSeen, 1'h0, "false loss");
        cycle_power(8'h00);
        $display("orderly done");
    endtask : t_orderly
    task automatic t_acloss;
        policy = 2'h2;
        sysOn = 1'h1;
        cyc(3);
        sysOn = 1'h0;
        cyc(4);
        acOn = 1'h0;
        cyc(2);
        chk(acLossSeen, 1'h1, "loss not seen");
        chk(orderlyOff, 1'h0, "orderly on loss");
        cycle_power(8'h01);
        sysOn = 1'h1;
        cyc(3);
        cycle_power(8'h01);
        railPresent = 1'h0;
        cycle_power(8'h00);
        railPresent = 1'h1;
        $display("acloss done");
    endtask : t_acloss
    task automatic final_report;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    initial begin
        benchRst_b = 1'h0;
        porRst_b = 1'h0;
        acOn = 1'h1;
        railPresent = 1'h1;
        policy = 2'h1;
        sysOn = 1'h0;
        cyc(10);
        benchRst_b = 1'h1;
        porRst_b = 1'h1;
        cyc(10);
        t_policies();
        t_orderly();
        t_acloss();
        final_report();
    end
    initial begin
        #(100 * 20000);
        errors++;
        final_report();
    end
endmodule : plrc_power_loss_ctrl_tb_top
`default_nettype wire
